// [rtl/xor_consts.vh]
`ifndef XOR_CONSTS_VH
`define XOR_CONSTS_VH
// register offsets from the operational base
`define XOR_OFS_COMMAND     12'h000
`define XOR_OFS_STATUS      12'h004
`define XOR_OFS_PAGE_SIZE   12'h008
`define XOR_OFS_NOTIFY      12'h014
`define XOR_OFS_CRC_LO      12'h018
`define XOR_OFS_CRC_HI      12'h01C
// command register fields
`define XOR_CMD_RUN         0
`define XOR_CMD_RESET       1
`define XOR_CMD_IRQEN       2
`define XOR_CMD_SEE         3
`define XOR_CMD_LRESET      7
`define XOR_CMD_SAVE        8
`define XOR_CMD_RESTORE     9
`define XOR_CMD_WRAP        10
`define XOR_CMD_U3STOP      11
`define XOR_CMD_WMASK       32'h00000F8F
// status register fields
`define XOR_STS_HALTED      0
`define XOR_STS_SYSERR      2
`define XOR_STS_EVENT       3
`define XOR_STS_PORTCHG     4
`define XOR_STS_SAVING      8
`define XOR_STS_RESTORING   9
`define XOR_STS_SRERR       10
`define XOR_STS_NOTREADY    11
`define XOR_STS_CTRLERR     12
`define XOR_STS_RESET       32'h00000801
// other values
`define XOR_PAGE_SIZE_VAL   32'h00000001
`define XOR_NOTIFY_WMASK    32'h0000FFFF
`define XOR_CMD_RESET_VAL   32'h00000000
`define XOR_NOTIFY_RESET    16'h0000
`define XOR_CRC_RESET       64'h0000000000000000
`endif

// [rtl/xor_rc_flag.v]
`include "xor_consts.vh"

// read-clear flag: event set wins over a read clear in the same cycle
module xor_rc_flag
(
    input  wire clk,
    input  wire rst,
    input  wire set_pulse,
    input  wire rd_clear,
    output reg  flag_q
);

    // set dominates so an event coincident with the read is kept
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            flag_q <= 1'b0;
        else if (set_pulse)
            flag_q <= 1'b1;
        else if (rd_clear)
            flag_q <= 1'b0;
    end

endmodule // xor_rc_flag

// [rtl/xor_op_regs.v]
`include "xor_consts.vh"

// Overview of operation
// - registers decode at offsets relative to the operational base address.
// - command bits 31:12 and 6:4 are reserved and read zero.
// - command bits 0..3: run/stop, reset, interrupter enable, error enable.
// - command bits 7..11: light reset, save, restore, wrap, U3 index stop.
// - status reads 0000_0801h after reset: halted and not ready set.
// - save/restore error, port change, event, system error clear on read.
// - error, not ready, restore, save, halted mirror state; others read zero.
// - page size is read-only and reads one (4k pages).
// - notification control holds sixteen read/write enables, upper half zero.
// - notification control resets to zero.
// - 64-bit command ring control register resets to zero.
module xor_op_regs
#(
    parameter ADDR_W = 12
)
(
    input  wire              clk,
    input  wire              rst,
    // register port, addressed from the operational base
    input  wire [ADDR_W-1:0] reg_addr,
    input  wire              reg_wr,
    input  wire              reg_rd,
    input  wire [31:0]       reg_wdata,
    input  wire [3:0]        reg_be,
    output reg  [31:0]       reg_rdata,
    output reg               reg_rvalid,
    // control outputs to the internal engines
    output reg               run_stop,
    output reg               controller_reset,
    output reg               interrupter_enable,
    output reg               system_error_enable,
    output reg               light_controller_reset,
    output reg               save_state_cmd,
    output reg               restore_state_cmd,
    output reg               wrap_event_enable,
    output reg               frame_index_stop_u3,
    output reg  [15:0]       notification_enables,
    output reg  [63:0]       command_ring_control,
    // state and events from the internal engines
    input  wire              halted_in,
    input  wire              not_ready_in,
    input  wire              controller_error_in,
    input  wire              save_in_progress_in,
    input  wire              restore_in_progress_in,
    input  wire              system_error_set,
    input  wire              event_interrupt_set,
    input  wire              port_change_set,
    input  wire              save_restore_error_set
);

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    localparam [ADDR_W-1:0] A_CMD  = `XOR_OFS_COMMAND;
    localparam [ADDR_W-1:0] A_STS  = `XOR_OFS_STATUS;
    localparam [ADDR_W-1:0] A_PGS  = `XOR_OFS_PAGE_SIZE;
    localparam [ADDR_W-1:0] A_NTF  = `XOR_OFS_NOTIFY;
    localparam [ADDR_W-1:0] A_CRL  = `XOR_OFS_CRC_LO;
    localparam [ADDR_W-1:0] A_CRH  = `XOR_OFS_CRC_HI;

    reg         hit_cmd;
    reg         hit_sts;
    reg         hit_pgs;
    reg         hit_ntf;
    reg         hit_crl;
    reg         hit_crh;
    wire [31:0] be_mask;

    // one-hot decode from the operational base
    always @*
    begin
        hit_cmd = 1'b0;
        hit_sts = 1'b0;
        hit_pgs = 1'b0;
        hit_ntf = 1'b0;
        hit_crl = 1'b0;
        hit_crh = 1'b0;
        if (reg_addr == A_CMD)
            hit_cmd = 1'b1;
        else if (reg_addr == A_STS)
            hit_sts = 1'b1;
        else if (reg_addr == A_PGS)
            hit_pgs = 1'b1;
        else if (reg_addr == A_NTF)
            hit_ntf = 1'b1;
        else if (reg_addr == A_CRL)
            hit_crl = 1'b1;
        else if (reg_addr == A_CRH)
            hit_crh = 1'b1;
    end

    // byte enables widened to a bit mask
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_be
            assign be_mask[gi*8 +: 8] = {8{reg_be[gi]}};
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // command register

    wire [31:0] cmd_wmask = `XOR_CMD_WMASK & be_mask;
    reg  [31:0] cmd_q;
    reg  [31:0] cmd_d;

    // only the nine rw bits take writes; reserved stays zero
    always @*
    begin
        cmd_d = cmd_q;
        if (reg_wr && hit_cmd)
            cmd_d = (cmd_q & ~cmd_wmask) | (reg_wdata & cmd_wmask);
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
            cmd_q <= `XOR_CMD_RESET_VAL;
        else
            cmd_q <= cmd_d & `XOR_CMD_WMASK;
    end

    ////////////////////////////////////////////////////////////////////////////
    // notification control and command ring control

    reg [15:0] ntf_q;
    reg [63:0] crc_q;

    // upper half of notification control is never stored
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ntf_q <= `XOR_NOTIFY_RESET;
            crc_q <= `XOR_CRC_RESET;
        end
        else if (reg_wr)
        begin
            if (hit_ntf)
                ntf_q <= (ntf_q & ~be_mask[15:0]) | (reg_wdata[15:0] & be_mask[15:0]);
            if (hit_crl)
                crc_q[31:0] <= (crc_q[31:0] & ~be_mask) | (reg_wdata & be_mask);
            if (hit_crh)
                crc_q[63:32] <= (crc_q[63:32] & ~be_mask) | (reg_wdata & be_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status register

    wire rd_sts = reg_rd && hit_sts;
    wire srerr_q;
    wire portchg_q;
    wire ein_q;
    wire syserr_q;

    // read-clear flags: writes have no path in
    xor_rc_flag u_srerr
    (
        .clk       (clk),
        .rst       (rst),
        .set_pulse (save_restore_error_set),
        .rd_clear  (rd_sts),
        .flag_q    (srerr_q)
    );

    xor_rc_flag u_portchg
    (
        .clk       (clk),
        .rst       (rst),
        .set_pulse (port_change_set),
        .rd_clear  (rd_sts),
        .flag_q    (portchg_q)
    );

    xor_rc_flag u_ein
    (
        .clk       (clk),
        .rst       (rst),
        .set_pulse (event_interrupt_set),
        .rd_clear  (rd_sts),
        .flag_q    (ein_q)
    );

    xor_rc_flag u_syserr
    (
        .clk       (clk),
        .rst       (rst),
        .set_pulse (system_error_set),
        .rd_clear  (rd_sts),
        .flag_q    (syserr_q)
    );

    // mirrored state registered once so reset shows 0801h
    reg halted_q;
    reg notrdy_q;
    reg ctlerr_q;
    reg saving_q;
    reg restoring_q;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            halted_q    <= 1'b1;
            notrdy_q    <= 1'b1;
            ctlerr_q    <= 1'b0;
            saving_q    <= 1'b0;
            restoring_q <= 1'b0;
        end
        else
        begin
            halted_q    <= halted_in;
            notrdy_q    <= not_ready_in;
            ctlerr_q    <= controller_error_in;
            saving_q    <= save_in_progress_in;
            restoring_q <= restore_in_progress_in;
        end
    end

    reg [31:0] sts_val;

    // assemble status; unlisted bits stay zero
    always @*
    begin
        sts_val                     = 32'h00000000;
        sts_val[`XOR_STS_HALTED]    = halted_q;
        sts_val[`XOR_STS_SYSERR]    = syserr_q;
        sts_val[`XOR_STS_EVENT]     = ein_q;
        sts_val[`XOR_STS_PORTCHG]   = portchg_q;
        sts_val[`XOR_STS_SAVING]    = saving_q;
        sts_val[`XOR_STS_RESTORING] = restoring_q;
        sts_val[`XOR_STS_SRERR]     = srerr_q;
        sts_val[`XOR_STS_NOTREADY]  = notrdy_q;
        sts_val[`XOR_STS_CTRLERR]   = ctlerr_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data

    reg [31:0] rdata_d;

    // unmapped offsets read zero
    always @*
    begin
        rdata_d = 32'h00000000;
        if (hit_cmd)
            rdata_d = cmd_q;
        else if (hit_sts)
            rdata_d = sts_val;
        else if (hit_pgs)
            rdata_d = `XOR_PAGE_SIZE_VAL;
        else if (hit_ntf)
            rdata_d = {16'h0000, ntf_q};
        else if (hit_crl)
            rdata_d = crc_q[31:0];
        else if (hit_crh)
            rdata_d = crc_q[63:32];
    end

    // read data captured with the pre-clear flag values
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata  <= 32'h00000000;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
                reg_rdata <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control outputs: command bits registered from cmd_d with the stored field, enables and ring copied from the stored fields

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            run_stop               <= 1'b0;
            controller_reset       <= 1'b0;
            interrupter_enable     <= 1'b0;
            system_error_enable    <= 1'b0;
            light_controller_reset <= 1'b0;
            save_state_cmd         <= 1'b0;
            restore_state_cmd      <= 1'b0;
            wrap_event_enable      <= 1'b0;
            frame_index_stop_u3    <= 1'b0;
            notification_enables   <= 16'h0000;
            command_ring_control   <= 64'h0000000000000000;
        end
        else
        begin
            run_stop               <= cmd_d[`XOR_CMD_RUN];
            controller_reset       <= cmd_d[`XOR_CMD_RESET];
            interrupter_enable     <= cmd_d[`XOR_CMD_IRQEN];
            system_error_enable    <= cmd_d[`XOR_CMD_SEE];
            light_controller_reset <= cmd_d[`XOR_CMD_LRESET];
            save_state_cmd         <= cmd_d[`XOR_CMD_SAVE];
            restore_state_cmd      <= cmd_d[`XOR_CMD_RESTORE];
            wrap_event_enable      <= cmd_d[`XOR_CMD_WRAP];
            frame_index_stop_u3    <= cmd_d[`XOR_CMD_U3STOP];
            notification_enables   <= ntf_q;
            command_ring_control   <= crc_q;
        end
    end

endmodule // xor_op_regs

// [dv/xor_op_regs_properties.sv]
module xor_op_regs_properties
(
    input logic        clk,
    input logic        rst,
    input logic [11:0] reg_addr,
    input logic        reg_wr,
    input logic        reg_rd,
    input logic [31:0] reg_wdata,
    input logic [3:0]  reg_be,
    input logic [31:0] reg_rdata,
    input logic        run_stop,
    input logic [15:0] notification_enables,
    input logic [63:0] command_ring_control,
    input logic        halted_in,
    input logic        event_interrupt_set
);
timeunit 1ns;
timeprecision 1ps;
// decoded read and write strobes
wire rd_cmd  = reg_rd && reg_addr == 12'h000;
wire rd_sts  = reg_rd && reg_addr == 12'h004;
wire wr_full = reg_wr && reg_be == 4'hF;
// one clock, reset disables all
default clocking @(posedge clk);
endclocking
default disable iff (rst);
// reserved and constant fields
AST_CMD_RSVD: assert property (rd_cmd |=> (reg_rdata & 32'hFFFFF070) == 32'h0)
    else $error("cmd reserved");
AST_STS_RSVD: assert property (rd_sts |=> (reg_rdata & 32'hFFFFE0E2) == 32'h0)
    else $error("sts reserved");
AST_PAGE: assert property (reg_rd && reg_addr == 12'h008 |=> reg_rdata == 32'h1)
    else $error("page size");
// halted is a registered copy, so it lags the input by two edges at the answer
AST_HALT: assert property (rd_sts |=> reg_rdata[0] == $past(halted_in, 2))
    else $error("halted");
AST_EVT_SET: assert property (event_interrupt_set ##1 rd_sts |=> reg_rdata[3])
    else $error("event lost");
AST_EVT_CLR: assert property (rd_sts && !event_interrupt_set ##1 rd_sts |=> !reg_rdata[3])
    else $error("event kept");
// stored controls follow the written data
AST_RUN: assert property (reg_wr && reg_addr == 12'h000 && reg_be[0]
    |=> run_stop == $past(reg_wdata[0])) else $error("run bit");
// enables and ring outputs copy the stored fields, so they follow one edge later
AST_NOTIFY: assert property (wr_full && reg_addr == 12'h014
    |=> ##1 notification_enables == $past(reg_wdata[15:0], 2)) else $error("enables");
AST_RING: assert property (wr_full && reg_addr == 12'h018
    |=> ##1 command_ring_control[31:0] == $past(reg_wdata, 2)) else $error("ring low");
// main scenarios reached
AST_COV_RD2: cover property (rd_sts ##1 rd_sts);
AST_COV_WIN: cover property (event_interrupt_set && rd_sts);
AST_COV_HI: cover property (wr_full && reg_addr == 12'h01C);
endmodule // xor_op_regs_properties
////////////////////////////////
bind xor_op_regs xor_op_regs_properties chk_u (.*);

// [dv/xhci_operational_registers_tb.sv]
module xhci_operational_registers_tb;
timeunit 1ns;
timeprecision 1ps;
logic        clk = 1'b0;
logic        rst = 1'b1;
logic [11:0] reg_addr = 12'h000;
logic        reg_wr = 1'b0;
logic        reg_rd = 1'b0;
logic [31:0] reg_wdata = 32'h0;
logic [3:0]  reg_be = 4'hF;
logic [4:0]  st_i = 5'h03; // error, restore, save, not ready, halted
logic [3:0]  ev_i = 4'h0; // sr error, port, event, sys error
logic [31:0] reg_rdata;
logic        reg_rvalid;
wire  [8:0]  cmd_o; // bits driven by separate output ports
logic [15:0] notify_o;
logic [63:0] ring_o;
int          bad_count = 0;
int          num_checks = 0;
// 50 MHz
always #10 clk = ~clk;
xor_op_regs dut_u
(
    .clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_be, .reg_rdata, .reg_rvalid,
    .run_stop(cmd_o[0]), .controller_reset(cmd_o[1]), .interrupter_enable(cmd_o[2]),
    .system_error_enable(cmd_o[3]), .light_controller_reset(cmd_o[4]),
    .save_state_cmd(cmd_o[5]), .restore_state_cmd(cmd_o[6]), .wrap_event_enable(cmd_o[7]),
    .frame_index_stop_u3(cmd_o[8]), .notification_enables(notify_o),
    .command_ring_control(ring_o), .halted_in(st_i[0]), .not_ready_in(st_i[1]),
    .save_in_progress_in(st_i[2]), .restore_in_progress_in(st_i[3]),
    .controller_error_in(st_i[4]), .system_error_set(ev_i[0]), .event_interrupt_set(ev_i[1]),
    .port_change_set(ev_i[2]), .save_restore_error_set(ev_i[3])
);
////////////////////////////////
task automatic chk(string n, logic [63:0] s, logic [63:0] e);
    num_checks++;
    if (s !== e)
    begin
        bad_count++;
        $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
endtask
// strobes rise and fall on falling edges, so one rising edge takes them
task automatic wr(logic [11:0] a, logic [31:0] d, logic [3:0] be);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_be = be;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
endtask
task automatic rdc(logic [11:0] a, logic [31:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk("rvalid", reg_rvalid, 1'b1);
    chk($sformatf("reg %h", a), reg_rdata, e);
endtask
task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask
task automatic t_reset;
    rdc(12'h000, 32'h0);
    rdc(12'h004, 32'h801);
    rdc(12'h008, 32'h1);
    rdc(12'h014, 32'h0);
    rdc(12'h018, 32'h0);
endtask
// all ones, then a low-byte-only clear
task automatic t_cmd;
    wr(12'h000, 32'hFFFFFFFF, 4'hF);
    chk("cmd_o", cmd_o, 9'h1FF);
    rdc(12'h000, 32'hF8F);
    wr(12'h000, 32'h0, 4'h1);
    chk("cmd_o low", cmd_o, 9'h1E0);
    rdc(12'h000, 32'hF00);
    wr(12'h000, 32'h0, 4'hF);
endtask
// flags survive a write; three reads in a row, event set during the first
task automatic t_status;
    @(negedge clk);
    st_i = 5'h1C;
    ev_i = 4'hF;
    @(negedge clk);
    ev_i = 4'h0;
    wr(12'h004, 32'hFFFFFFFF, 4'hF);
    @(negedge clk);
    reg_rd = 1'b1;
    ev_i = 4'h2;
    @(negedge clk);
    ev_i = 4'h0;
    chk("sts1", reg_rdata, 32'h171C);
    @(negedge clk);
    chk("sts2", reg_rdata, 32'h1308);
    @(negedge clk);
    reg_rd = 1'b0;
    chk("sts3", reg_rdata, 32'h1300);
endtask
task automatic t_regs;
    wr(12'h014, 32'hFFFFFFFF, 4'hF);
    @(negedge clk); // enables copy the stored field one edge later
    chk("notify_o", notify_o, 16'hFFFF);
    wr(12'h014, 32'h0, 4'h1);
    rdc(12'h014, 32'hFF00);
    wr(12'h018, 32'hA5A55A5A, 4'hF);
    wr(12'h01C, 32'h12345678, 4'hF);
    @(negedge clk); // ring output copies the stored field one edge later
    chk("ring_o", ring_o, 64'h12345678A5A55A5A);
    rdc(12'h01C, 32'h12345678);
    wr(12'h008, 32'hFFFFFFFF, 4'hF);
    rdc(12'h008, 32'h1);
    rdc(12'h00C, 32'h0);
endtask
// main sequence
initial
begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_cmd();
    t_status();
    t_regs();
    test_done();
end
// watchdog, several times the expected run
initial
begin
    #20us;
    bad_count++;
    test_done();
end
endmodule // xhci_operational_registers_tb
